//--- fwe_pkg.sv
// Constants and types shared by the flash write and erase control block
package fwe_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // Highest byte of user code space; writes above it trip an error reset
    localparam logic [15:0] USER_TOP_ADDR = 16'h7bff;
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'hf1;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam int PAGE_BYTES = 1024;
    localparam int PAGE_SHIFT = 10;
    // Control register field positions
    localparam int CTRL_WE_BIT = 0;
    localparam int CTRL_EE_BIT = 1;
    // Reset source register field position of the flash error flag
    localparam int RST_SRC_FLASH_ERR_BIT = 6;
    localparam logic WE_RST = 1'b0;
    localparam logic EE_RST = 1'b0;
    localparam logic FLASH_ERR_RST = 1'b0;
    // Hardware timing of one byte program and one page erase
    localparam int CLK_PERIOD_NS = 25;
    localparam int PROG_TIME_NS = 20000;
    localparam int ERASE_TIME_NS = 20000000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 20;
    typedef enum {SEQ_IDLE, SEQ_READ, SEQ_LATCH, SEQ_PROG, SEQ_ERASE} fwe_seq_t;
    typedef enum {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_BLOCKED} fwe_key_t;
endpackage

//--- fwe_key_if.sv
// Link between the sequencer and the lock and key unit
`timescale 1ns/1ps
interface fwe_key_if;
    logic keyWrEn;
    logic [7:0] keyWrData;
    logic attempt;
    logic unlocked;
    logic blocked;
    modport lock (
        input keyWrEn,
        input keyWrData,
        input attempt,
        output unlocked,
        output blocked
    );
    modport ctrl (
        output keyWrEn,
        output keyWrData,
        output attempt,
        input unlocked,
        input blocked
    );
endinterface

//--- fwe_key_lock.sv
// Two-code lock and key state machine guarding flash writes and erases
`timescale 1ns/1ps
module fwe_key_lock (
    input wire logic sys_clk,
    input wire logic rst_n,
    fwe_key_if.lock kif
);
    fwe_pkg::fwe_key_t state_r;
    fwe_pkg::fwe_key_t state_nxt;
    wire logic firstOk = kif.keyWrEn && (kif.keyWrData == fwe_pkg::KEY_FIRST);
    wire logic secondOk = kif.keyWrEn && (kif.keyWrData == fwe_pkg::KEY_SECOND);

    assign kif.unlocked = (state_r == fwe_pkg::KEY_OPEN);
    assign kif.blocked = (state_r == fwe_pkg::KEY_BLOCKED);

    // Next lock state; blocked is left only by system reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fwe_pkg::KEY_LOCKED: begin
                if (kif.attempt) begin
                    state_nxt = fwe_pkg::KEY_BLOCKED;
                end else if (firstOk) begin
                    state_nxt = fwe_pkg::KEY_HALF;
                end else if (kif.keyWrEn) begin
                    state_nxt = fwe_pkg::KEY_BLOCKED;
                end
            end
            fwe_pkg::KEY_HALF: begin
                if (kif.attempt) begin
                    state_nxt = fwe_pkg::KEY_BLOCKED;
                end else if (secondOk) begin
                    state_nxt = fwe_pkg::KEY_OPEN;
                end else if (kif.keyWrEn) begin
                    state_nxt = fwe_pkg::KEY_BLOCKED;
                end
            end
            fwe_pkg::KEY_OPEN: begin
                if (kif.attempt) begin
                    state_nxt = fwe_pkg::KEY_LOCKED;
                end else if (kif.keyWrEn) begin
                    state_nxt = fwe_pkg::KEY_BLOCKED;
                end
            end
            fwe_pkg::KEY_BLOCKED: state_nxt = fwe_pkg::KEY_BLOCKED;
            default: state_nxt = fwe_pkg::KEY_BLOCKED;
        endcase
    end

    // Reset returns to locked with no codes seen
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= fwe_pkg::KEY_LOCKED;
        end else begin
            state_r <= state_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Spacing between the codes is free, so each step is checked from its own state
    sequence firstKey;
        firstOk && state_r == fwe_pkg::KEY_LOCKED && !kif.attempt;
    endsequence
    sequence secondKey;
        secondOk && state_r == fwe_pkg::KEY_HALF && !kif.attempt;
    endsequence

    key_first_a: assert property (firstKey |=> state_r == fwe_pkg::KEY_HALF)
        else $error("first key code not accepted");
    key_pair_opens_a: assert property (secondKey |=> kif.unlocked)
        else $error("key pair did not unlock");
    block_sticks_a: assert property (kif.blocked |=> kif.blocked)
        else $error("blocked lock left without reset");
    early_attempt_a: assert property (!kif.unlocked && kif.attempt |=> kif.blocked)
        else $error("attempt while locked did not block");
    relock_after_a: assert property (kif.unlocked && kif.attempt |=> !kif.unlocked)
        else $error("lock not restored after operation");
endmodule

//--- fwe_flash_ctrl.sv
// Flash write and erase controller facing the processor core
//
// Summary of operation
// - Busy flag stays 1 through each write or erase, clears when done.
// - Core stalls only when it must fetch from flash while busy.
// - Interrupts not cached, or arriving while halted, wait until the operation ends.
// - Write enable set routes external-move writes to flash, else external RAM.
// - Write enable survives operations; only a software write of 0 or a system reset clears it.
// - External-move reads always go to external RAM; flash read by code moves.
// - Write or erase with the supply monitor off raises a flash error reset.
// - Byte writes only clear bits; only page erase sets them back to 1.
// - Write and erase durations are timed by hardware, completing unaided.
// - Key codes 0xA5 then 0xF1, any spacing, unlock one operation.
// - Wrong or out-of-order key code blocks writes and erases until reset.
// - Attempt before the full key sequence also blocks until reset.
// - Each operation re-locks; a fresh key pair is needed.
// - Write with both enables set erases the whole 1024-byte page to 0xFF.
// - A flash error reset sets the flash error flag, bit 6 of reset source.
// - Write enable set and address above 0x7BFF raises a flash error reset.
`timescale 1ns/1ps
module fwe_flash_ctrl #(
    parameter int INT_N = 8,
    parameter int ERASE_CYCLES = fwe_pkg::ERASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic porRst_n,
    input wire logic otherResetSeen,
    input wire logic keyWrEn,
    input wire logic [7:0] keyWrData,
    input wire logic ctrlWrEn,
    input wire logic [7:0] ctrlWrData,
    input wire logic xmoveWrEn,
    input wire logic xmoveRdEn,
    input wire logic [15:0] xmoveAddr,
    input wire logic [7:0] xmoveWrData,
    input wire logic codeRdEn,
    input wire logic [15:0] codeRdAddr,
    input wire logic fetchFromFlash,
    input wire logic coreHalted,
    input wire logic [INT_N-1:0] intReq,
    input wire logic [INT_N-1:0] intCached,
    input wire logic supplyMonOn,
    input wire logic [7:0] flashRdData,
    output logic programStoreWriteEnable,
    output logic programStoreEraseEnable,
    output logic flashBusyFlag,
    output logic stallCore,
    output logic [INT_N-1:0] intService,
    output logic xramWrEn,
    output logic xramRdEn,
    output logic [15:0] xramAddr,
    output logic [7:0] xramWrData,
    output logic flashRdEn,
    output logic [15:0] flashRdAddr,
    output logic flashProgEn,
    output logic flashEraseEn,
    output logic [15:0] flashAddr,
    output logic [7:0] flashWrData,
    output logic flashErrorReset,
    output logic flashErrorFlag
);
    localparam int CW = fwe_pkg::CNT_W;
    fwe_key_if kif();
    fwe_pkg::fwe_seq_t seq_r;
    fwe_pkg::fwe_seq_t seq_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic we_r, ee_r;
    logic [15:0] opAddr_r;
    logic [7:0] opData_r;
    logic [INT_N-1:0] pend_r;
    logic [INT_N-1:0] pend_nxt;
    logic [INT_N-1:0] grant;

    fwe_key_lock keyUnit (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .kif(kif)
    );

    // Attempt decode; writes arriving mid-operation are ignored
    wire logic idle = (seq_r == fwe_pkg::SEQ_IDLE);
    wire logic attempt = xmoveWrEn && we_r && idle;
    wire logic errRange = xmoveAddr > fwe_pkg::USER_TOP_ADDR;
    wire logic errAny = attempt && (errRange || !supplyMonOn);
    wire logic start = attempt && !errAny && kif.unlocked;
    wire logic busyNxt = (seq_nxt != fwe_pkg::SEQ_IDLE);
    wire logic [15:0] pageBase = {xmoveAddr[15:fwe_pkg::PAGE_SHIFT],
                                  {fwe_pkg::PAGE_SHIFT{1'b0}}};
    wire logic progAnd = (seq_r == fwe_pkg::SEQ_LATCH);
    wire logic codeRead = codeRdEn && idle && !attempt;
    assign kif.keyWrEn = keyWrEn;
    assign kif.keyWrData = keyWrData;
    assign kif.attempt = attempt && !errAny;

    // Sequencer: read old byte, program the AND, or erase the page
    always_comb begin
        seq_nxt = seq_r;
        cnt_nxt = cnt_r;
        case (seq_r)
            fwe_pkg::SEQ_IDLE: begin
                if (start && ee_r) begin
                    seq_nxt = fwe_pkg::SEQ_ERASE;
                    cnt_nxt = CW'(ERASE_CYCLES - 1);
                end else if (start) begin
                    seq_nxt = fwe_pkg::SEQ_READ;
                end
            end
            fwe_pkg::SEQ_READ: seq_nxt = fwe_pkg::SEQ_LATCH;
            fwe_pkg::SEQ_LATCH: begin
                seq_nxt = fwe_pkg::SEQ_PROG;
                cnt_nxt = CW'(fwe_pkg::PROG_CYCLES - 1);
            end
            fwe_pkg::SEQ_PROG, fwe_pkg::SEQ_ERASE: begin
                if (cnt_r == '0) begin
                    seq_nxt = fwe_pkg::SEQ_IDLE;
                end else begin
                    cnt_nxt = cnt_r - CW'(1);
                end
            end
            default: seq_nxt = fwe_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= fwe_pkg::SEQ_IDLE;
            cnt_r <= '0;
            flashBusyFlag <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            cnt_r <= cnt_nxt;
            flashBusyFlag <= busyNxt;
        end
    end

    // Enables change only by software writes or system reset; operations leave them alone
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            we_r <= fwe_pkg::WE_RST;
            ee_r <= fwe_pkg::EE_RST;
        end else if (ctrlWrEn) begin
            we_r <= ctrlWrData[fwe_pkg::CTRL_WE_BIT];
            ee_r <= ctrlWrData[fwe_pkg::CTRL_EE_BIT];
        end
    end
    assign programStoreWriteEnable = we_r;
    assign programStoreEraseEnable = ee_r;

    // Captured operation address and data
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            opAddr_r <= '0;
            opData_r <= '0;
        end else if (start) begin
            opAddr_r <= ee_r ? pageBase : xmoveAddr;
            opData_r <= xmoveWrData;
        end
    end

    // Flash array strobes; the AND keeps a write from setting bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flashRdEn <= 1'b0;
            flashRdAddr <= '0;
            flashProgEn <= 1'b0;
            flashEraseEn <= 1'b0;
            flashAddr <= '0;
            flashWrData <= fwe_pkg::ERASED_BYTE;
        end else begin
            flashRdEn <= (start && !ee_r) || codeRead;
            flashRdAddr <= start ? xmoveAddr : codeRdAddr;
            flashProgEn <= progAnd;
            flashEraseEn <= start && ee_r;
            if (progAnd) begin
                flashAddr <= opAddr_r;
                flashWrData <= flashRdData & opData_r;
            end else if (start && ee_r) begin
                flashAddr <= pageBase;
                flashWrData <= fwe_pkg::ERASED_BYTE;
            end
        end
    end

    // External RAM: writes only when flash writes are off, reads always
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xramWrEn <= 1'b0;
            xramRdEn <= 1'b0;
            xramAddr <= '0;
            xramWrData <= '0;
        end else begin
            xramWrEn <= xmoveWrEn && !we_r;
            xramRdEn <= xmoveRdEn;
            xramAddr <= xmoveAddr;
            xramWrData <= xmoveWrData;
        end
    end

    // Stall only on a fetch that misses prefetch and cache
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stallCore <= 1'b0;
        end else begin
            stallCore <= busyNxt && fetchFromFlash;
        end
    end

    // Pending interrupts; lowest index wins, a new request beats the clear
    always_comb begin
        grant = '0;
        for (int i = INT_N - 1; i >= 0; i--) begin
            if (pend_r[i] && (!flashBusyFlag || (intCached[i] && !coreHalted))) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
        pend_nxt = (pend_r & ~grant) | intReq;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= '0;
            intService <= '0;
        end else begin
            pend_r <= pend_nxt;
            intService <= grant;
        end
    end

    // Error reset request holds until the system reset takes it down
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flashErrorReset <= 1'b0;
        end else if (errAny) begin
            flashErrorReset <= 1'b1;
        end
    end

    // Cause flag lives on power-on reset so it survives the error reset
    always_ff @(posedge sys_clk or negedge porRst_n) begin
        if (!porRst_n) begin
            flashErrorFlag <= fwe_pkg::FLASH_ERR_RST;
        end else if (flashErrorReset) begin
            flashErrorFlag <= 1'b1;
        end else if (otherResetSeen) begin
            flashErrorFlag <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Array data one cycle late, to hold against the byte that gets programmed
    logic [7:0] flashRdData_q;
    always_ff @(posedge sys_clk) begin
        flashRdData_q <= flashRdData;
    end

    sequence byteStart;
        start && !ee_r;
    endsequence
    sequence progIssue;
        ##3 flashProgEn && flashWrData == (flashRdData_q & opData_r);
    endsequence

    busy_follows_a: assert property ((seq_r != fwe_pkg::SEQ_IDLE) |-> flashBusyFlag)
        else $error("busy flag low during operation");
    stall_cause_a: assert property (stallCore |-> $past(busyNxt && fetchFromFlash))
        else $error("stall without busy flash fetch");
    int_held_a: assert property (flashBusyFlag && coreHalted |=> intService == '0)
        else $error("interrupt serviced while halted and busy");
    wr_route_a: assert property (xmoveWrEn && we_r |=> !xramWrEn)
        else $error("external write reached RAM with flash write enabled");
    we_keep_a: assert property (we_r && !ctrlWrEn |=> we_r)
        else $error("write enable dropped without software");
    rd_route_a: assert property (xmoveRdEn |=> xramRdEn)
        else $error("external read not sent to RAM");
    supply_err_a: assert property (attempt && !supplyMonOn |=> flashErrorReset)
        else $error("no error reset with supply monitor off");
    and_prog_a: assert property (byteStart |-> progIssue)
        else $error("byte program data not old AND new");
    prog_count_a: assert property (seq_r == fwe_pkg::SEQ_PROG && cnt_r != '0
        |=> seq_r == fwe_pkg::SEQ_PROG && cnt_r == $past(cnt_r) - CW'(1))
        else $error("program timer not counting");
    erase_page_a: assert property (start && ee_r |=> flashEraseEn && flashAddr[9:0] == '0
        && flashWrData == fwe_pkg::ERASED_BYTE)
        else $error("page erase not issued on page base");
    range_err_a: assert property (attempt && errRange |=> flashErrorReset && !flashBusyFlag)
        else $error("write above user space not trapped");
    err_flag_a: assert property (@(posedge sys_clk) disable iff (!porRst_n)
        flashErrorReset |=> flashErrorFlag)
        else $error("flash error flag not set");
    // Code reads reach the array only while no operation runs
    code_rd_a: assert property (codeRead |=> flashRdEn && flashRdAddr == $past(codeRdAddr))
        else $error("code read not sent to flash");
    // Once idle, a pending interrupt must be released at once
    int_free_a: assert property (!flashBusyFlag && pend_r != '0 |=> intService != '0)
        else $error("pending interrupt not serviced when idle");
    we_write_a: assert property (ctrlWrEn |=> we_r == $past(ctrlWrData[fwe_pkg::CTRL_WE_BIT]))
        else $error("write enable not taken from software write");
endmodule

//--- fwe_flash_array_model.sv
// Behavioural model of the flash array behind the write and erase controller
`timescale 1ns/1ps
module fwe_flash_array_model (
    input wire logic sys_clk,
    input wire logic flashRdEn,
    input wire logic [15:0] flashRdAddr,
    input wire logic flashProgEn,
    input wire logic flashEraseEn,
    input wire logic [15:0] flashAddr,
    input wire logic [7:0] flashWrData,
    output logic [7:0] flashRdData
);
    logic [7:0] mem [logic [15:0]];

    // Unwritten bytes read as erased
    function automatic logic [7:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction

    initial flashRdData = 8'h00;

    // Read data is only good for one cycle; it toggles otherwise so stale reads show up
    always @(posedge sys_clk) begin
        flashRdData <= flashRdEn ? peek(flashRdAddr) : ~flashRdData;
        if (flashProgEn) begin
            mem[flashAddr] = peek(flashAddr) & flashWrData;
        end
        if (flashEraseEn) begin
            for (int i = 0; i < fwe_pkg::PAGE_BYTES; i++) begin
                mem[{flashAddr[15:10], 10'h000} + 16'(i)] = 8'hff;
            end
        end
    end
endmodule

//--- fwe_flash_ctrl_tb.sv
// Self-checking testbench for the flash write and erase controller
`timescale 1ns/1ps
module fwe_flash_ctrl_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic porRst_n = 1'b0;
    logic keyWrEn = 1'b0;
    logic [7:0] keyWrData = 8'h00;
    logic ctrlWrEn = 1'b0;
    logic [7:0] ctrlWrData = 8'h00;
    logic xmoveWrEn = 1'b0;
    logic xmoveRdEn = 1'b0;
    logic [15:0] xmoveAddr = 16'h0000;
    logic [7:0] xmoveWrData = 8'h00;
    logic codeRdEn = 1'b0;
    logic [15:0] codeRdAddr = 16'h0000;
    logic fetchFromFlash = 1'b0;
    logic [7:0] intReq = 8'h00;
    logic supplyMonOn = 1'b1;
    logic coreHalted = 1'b0;
    logic otherResetSeen = 1'b0;
    logic [7:0] intCached = 8'h00;
    logic [7:0] flashRdData;
    logic weOut, eeOut, flashBusyFlag, stallCore, xramWrEn, xramRdEn, flashRdEn;
    logic flashProgEn, flashEraseEn, flashErrorReset, flashErrorFlag;
    logic [7:0] intService, xramWrData, flashWrData;
    logic [15:0] xramAddr, flashRdAddr, flashAddr;
    int nErrors = 0;
    int cmpCount = 0;
    int nXw = 0;
    int nProg = 0;
    int nErase = 0;
    int svcBusy = 0;
    logic [7:0] svcSeen = 8'h00;
    int n;

    always #12.5 sys_clk = ~sys_clk;

    fwe_flash_ctrl #(.INT_N(8), .ERASE_CYCLES(20)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .porRst_n(porRst_n),
        .otherResetSeen(otherResetSeen),
        .keyWrEn(keyWrEn), .keyWrData(keyWrData), .ctrlWrEn(ctrlWrEn),
        .ctrlWrData(ctrlWrData), .xmoveWrEn(xmoveWrEn), .xmoveRdEn(xmoveRdEn),
        .xmoveAddr(xmoveAddr), .xmoveWrData(xmoveWrData), .codeRdEn(codeRdEn),
        .codeRdAddr(codeRdAddr), .fetchFromFlash(fetchFromFlash), .coreHalted(coreHalted),
        .intReq(intReq), .intCached(intCached), .supplyMonOn(supplyMonOn),
        .flashRdData(flashRdData), .programStoreWriteEnable(weOut),
        .programStoreEraseEnable(eeOut), .flashBusyFlag(flashBusyFlag),
        .stallCore(stallCore), .intService(intService), .xramWrEn(xramWrEn),
        .xramRdEn(xramRdEn), .xramAddr(xramAddr), .xramWrData(xramWrData),
        .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr), .flashProgEn(flashProgEn),
        .flashEraseEn(flashEraseEn), .flashAddr(flashAddr), .flashWrData(flashWrData),
        .flashErrorReset(flashErrorReset), .flashErrorFlag(flashErrorFlag)
    );

    fwe_flash_array_model flash_u (
        .sys_clk(sys_clk), .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr),
        .flashProgEn(flashProgEn), .flashEraseEn(flashEraseEn), .flashAddr(flashAddr),
        .flashWrData(flashWrData), .flashRdData(flashRdData)
    );

    // Strobe counters, so refused operations can be spotted after the fact
    always @(posedge sys_clk) begin
        nXw += xramWrEn;
        nProg += flashProgEn;
        nErase += flashEraseEn;
        if (flashBusyFlag && |intService) svcBusy++;
        svcSeen |= intService;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One core access: 0 key, 1 control, 2 ext write, 3 ext read, 4 code read
    task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        keyWrEn <= (k == 0);
        ctrlWrEn <= (k == 1);
        xmoveWrEn <= (k == 2);
        xmoveRdEn <= (k == 3);
        codeRdEn <= (k == 4);
        keyWrData <= d;
        ctrlWrData <= d;
        xmoveWrData <= d;
        xmoveAddr <= a;
        codeRdAddr <= a;
        @(posedge sys_clk);
        {keyWrEn, ctrlWrEn, xmoveWrEn, xmoveRdEn, codeRdEn} <= 5'h00;
        @(negedge sys_clk);
    endtask

    task automatic unlockWrite(input logic [7:0] ctl, input logic [15:0] a,
            input logic [7:0] d);
        op(0, 16'h0000, fwe_pkg::KEY_FIRST);
        op(0, 16'h0000, fwe_pkg::KEY_SECOND);
        op(1, 16'h0000, ctl);
        op(2, a, d);
    endtask

    // Bounded wait for the busy flag to drop; counts cycles seen busy
    task automatic waitIdle(output int cnt);
        cnt = 0;
        while (flashBusyFlag !== 1'b0 && cnt < 2000) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask

    task automatic doReset;
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        porRst_n <= 1'b1;
        @(negedge sys_clk);
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog sized well beyond the roughly 2700 cycles the sequence needs
    initial begin
        repeat (40000) @(posedge sys_clk);
        nErrors++;
        results();
    end

    initial begin
        doReset();
        check({weOut, eeOut, flashBusyFlag, flashErrorReset}, 16'h0000);
        op(2, 16'h0040, 8'h3c);
        check({xramWrEn, xramAddr}, {1'b1, 16'h0040});
        check(xramWrData, 16'h003c);
        op(1, 16'h0000, 8'h01);
        op(3, 16'h0040, 8'h00);
        check({xramRdEn, xramAddr}, {1'b1, 16'h0040});
        // First byte program, timed end to end
        unlockWrite(8'h01, 16'h0100, 8'h5a);
        waitIdle(n);
        check(n, fwe_pkg::PROG_CYCLES + 2);
        check(nProg, 1);
        check(nXw, 1);
        check(weOut, 1'b1);
        check(flash_u.peek(16'h0100), 16'h005a);
        // Second program over the first while the core wants flash and an interrupt arrives
        unlockWrite(8'h01, 16'h0100, 8'ha5);
        @(posedge sys_clk);
        fetchFromFlash <= 1'b1;
        repeat (10) @(negedge sys_clk);
        check(stallCore, 1'b1);
        @(posedge sys_clk);
        fetchFromFlash <= 1'b0;
        intCached <= 8'h02;
        intReq <= 8'h0a;
        @(posedge sys_clk);
        intReq <= 8'h00;
        waitIdle(n);
        repeat (5) @(negedge sys_clk);
        check(svcSeen, 8'h0a);
        check(svcBusy, 1);
        check(stallCore, 1'b0);
        op(4, 16'h0100, 8'h00);
        check({flashRdEn, flashRdAddr}, {1'b1, 16'h0100});
        @(negedge sys_clk);
        check(flashRdData, 16'h0000);
        // Page erase from a mid-page address
        unlockWrite(8'h03, 16'h0123, 8'h00);
        waitIdle(n);
        check(nErase, 1);
        check(flash_u.peek(16'h0100), 16'h00ff);
        op(1, 16'h0000, 8'h00);
        check({weOut, eeOut}, 16'h0000);
        // No fresh key: attempt blocks, then even a good key cannot reopen
        op(1, 16'h0000, 8'h01);
        op(2, 16'h0200, 8'h11);
        unlockWrite(8'h01, 16'h0200, 8'h11);
        repeat (5) @(negedge sys_clk);
        check({flashBusyFlag, 15'(nProg)}, {1'b0, 15'd2});
        // Wrong second code locks out until reset, reset clears it
        doReset();
        op(0, 16'h0000, fwe_pkg::KEY_FIRST);
        op(0, 16'h0000, 8'h12);
        unlockWrite(8'h01, 16'h0200, 8'h11);
        repeat (5) @(negedge sys_clk);
        check(nProg, 2);
        doReset();
        unlockWrite(8'h01, 16'h0200, 8'h11);
        // Cached interrupt arriving while the core is halted must wait
        @(posedge sys_clk);
        coreHalted <= 1'b1;
        intReq <= 8'h02;
        @(posedge sys_clk);
        intReq <= 8'h00;
        waitIdle(n);
        check(svcBusy, 1);
        check(nProg, 3);
        @(posedge sys_clk);
        coreHalted <= 1'b0;
        // Supply monitor off: error reset, flag survives system reset
        @(posedge sys_clk);
        supplyMonOn <= 1'b0;
        unlockWrite(8'h01, 16'h0300, 8'h22);
        check(flashErrorReset, 1'b1);
        repeat (3) @(negedge sys_clk);
        check(nProg, 3);
        doReset();
        check({flashErrorFlag, weOut, eeOut}, 16'h0004);
        // A later reset of another cause clears the flag
        @(posedge sys_clk);
        otherResetSeen <= 1'b1;
        @(posedge sys_clk);
        otherResetSeen <= 1'b0;
        @(negedge sys_clk);
        check(flashErrorFlag, 1'b0);
        // Reserved region above user space
        @(posedge sys_clk);
        supplyMonOn <= 1'b1;
        unlockWrite(8'h01, 16'h7c00, 8'h33);
        check(flashErrorReset, 1'b1);
        repeat (3) @(negedge sys_clk);
        check(nProg, 3);
        doReset();
        results();
    end
endmodule
